/* File: smoc_pkg.sv */
/*
 * Constants and carrier types for the synchronous modem output section
 * and command decoder.
 * Assumes host words use big-endian bit numbering: bit 0 is the MSB.
 */
// Function
// - Take one host byte in parallel, shift it out on the transmit clock.
// - Load holding register only when empty and data set mode permits.
// - On clear-to-send, move holding to shifter, mark empty, request.
// - Host refills before the word just moved has been shifted out, else output timing error.
// - Transmit line idles at mark (one) whenever no data is sent.
// - No parity generated or checked; eight host bits go out unchanged.
// - While dialing, bits 08-11 give the BCD digit; bits 12-15 ignored.
// - Each dialer next-digit signal while dialing raises an output service request.
// - Two addresses share upper seven bits; odd is input, even output.
// - Section service requests on the listed data set and data events.
// - Dialer next-digit (while dialing) and abandon-call also raise output requests.
// - Command decoded from bits 12-15; bits 0-11 ignored.
// - Commands acknowledged except refused send and call requests; no request.
// - Input commands clear input request; accepted output ones clear.
// - Code 4 drops and masks section request, keeps service-required.
// - Code 8 unmasks; a pending condition raises the request at once.
// - Input code 9 asserts terminal-ready; needed before call request (output code 9 is accepted without it).
// - Input code 5 deasserts terminal-ready.
// - Output code 1 asserts request-to-send; acknowledged in data mode.
// - Output code 5 deasserts request-to-send.
// - Input code 1 drops sync and rearms input framing.
// - Output code 9 refused while line occupied, else off hook.
// - Output code D marks dialing complete.
// - Data out acknowledged only when the holding register is free.
// - Status read clears section timing error and drops its request.
package smoc_pkg;

	typedef enum logic [1:0] {
		SMOC_OP_CMD,
		SMOC_OP_DATA_OUT,
		SMOC_OP_STATUS_IN,
		SMOC_OP_NONE
	} smoc_op_e;

	// One host transfer; acc uses bit 0 as the most significant bit
	typedef struct packed {
		logic valid;
		smoc_op_e op;
		logic [7:0] addr;
		logic [0:15] acc;
	} smoc_req_s;

	// Synchronised data set and dialer pins
	typedef struct packed {
		logic ready;
		logic cts;
		logic carrier;
		logic next_digit;
		logic abandon;
		logic occupied;
	} smoc_pins_s;

	localparam int SMOC_PIN_W = 6;
	localparam int SMOC_BYTE_BITS = 8;
	localparam logic [2:0] SMOC_LAST_BIT = 3'h7;

	// Command codes
	localparam logic [3:0] SMOC_CMD_MASK = 4'h4;
	localparam logic [3:0] SMOC_CMD_UNMASK = 4'h8;
	localparam logic [3:0] SMOC_CMD_ON = 4'h9;
	localparam logic [3:0] SMOC_CMD_OFF = 4'h5;
	localparam logic [3:0] SMOC_CMD_ONE = 4'h1;
	localparam logic [3:0] SMOC_CMD_DIAL_DONE = 4'hD;

	// Status bit positions
	localparam int SMOC_ST_READY = 15;
	localparam int SMOC_ST_TERR = 13;
	localparam int SMOC_ST_CTS = 12;
	localparam int SMOC_ST_CARRIER = 12;
	localparam int SMOC_ST_NEXT = 11;
	localparam int SMOC_ST_ABANDON = 9;
	localparam int SMOC_ST_OCCUPIED = 8;

	// Default base address, reset values and idle line level
	localparam logic [7:0] SMOC_BASE_ADDR = 8'h40;
	localparam logic [7:0] SMOC_HOLD_RST = 8'hFF;
	localparam logic SMOC_MARK = 1'b1;

endpackage

/* File: smoc_sync.sv */
/*
 * Two flip-flop synchroniser for a bundle of level signals.
 * Assumes each bit changes slowly or is a toggle held stable.
 */
`timescale 1ns/10ps
module smoc_sync #(
	parameter int W = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule

/* File: smoc_top.sv */
/*
 * Output section and command decoder of a synchronous modem controller.
 * Host transfers arrive as one-cycle requests on sys_clk; the serial
 * side runs on the data set transmit clock, which must run freely.
 */
`timescale 1ns/10ps
module smoc_top #(
	parameter logic [7:0] BASE_ADDR = smoc_pkg::SMOC_BASE_ADDR
) (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic tx_clk,
	// Host channel
	input wire smoc_pkg::smoc_req_s host_req,
	output logic host_ack,
	output logic [0:15] status_data,
	output logic out_srq,
	output logic in_srq,
	// Data set pins
	input wire logic ds_ready,
	input wire logic ds_cts,
	input wire logic ds_carrier,
	output logic rts,
	output logic terminal_ready,
	output logic txd,
	// Dialer pins
	input wire logic dial_next_digit,
	input wire logic dial_abandon,
	input wire logic dial_occupied,
	output logic dial_off_hook,
	output logic [3:0] dial_digit,
	output logic dial_digit_valid,
	// Input section hooks
	input wire logic in_data_event,
	input wire logic in_terr_event,
	output logic rearm_input
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	smoc_pkg::smoc_pins_s pins;
	smoc_pkg::smoc_pins_s pins_d_reg;
	logic link_ack_s;
	logic link_err_s;
	logic link_ack_tgl_reg;
	logic link_err_tgl_reg;

	smoc_sync #(.W(smoc_pkg::SMOC_PIN_W + 2)) u_pin_sync (
		.clk(sys_clk),
		.rst_n(resetn),
		.d({ds_ready, ds_cts, ds_carrier, dial_next_digit, dial_abandon,
			dial_occupied, link_ack_tgl_reg, link_err_tgl_reg}),
		.q({pins, link_ack_s, link_err_s})
	);

	////////////////////////////////////////////////////////////////////////
	// Decode

	logic sel;
	logic is_in;
	logic [3:0] code;
	logic is_cmd;
	logic is_dout;
	logic is_stat;

	assign sel = host_req.valid
		&& (host_req.addr[7:1] == BASE_ADDR[7:1]);
	assign is_in = host_req.addr[0];
	assign code = host_req.acc[12:15];
	assign is_cmd = sel && (host_req.op == smoc_pkg::SMOC_OP_CMD);
	assign is_dout = sel && !is_in && (host_req.op == smoc_pkg::SMOC_OP_DATA_OUT);
	assign is_stat = sel && (host_req.op == smoc_pkg::SMOC_OP_STATUS_IN);

	logic rts_reg;
	logic tr_reg;
	logic dialing_reg;
	logic hold_full_reg;
	logic [0:7] hold_reg;
	// Word handed to the transmit clock; steady until the toggle returns
	logic [0:7] link_word_reg;
	logic oerr_reg;
	logic ierr_reg;
	logic abandon_reg;
	logic xfer_req_reg;
	logic ack_seen_reg;
	logic err_seen_reg;

	function automatic logic out_cmd(input logic [3:0] c, input logic [3:0] v);
		return is_cmd && !is_in && (c == v);
	endfunction

	function automatic logic in_cmd(input logic [3:0] c, input logic [3:0] v);
		return is_cmd && is_in && (c == v);
	endfunction

	logic rts_cmd;
	logic call_cmd;
	logic cmd_ack;
	logic dout_ack;
	logic hold_moves;
	logic underrun;

	assign rts_cmd = out_cmd(code, smoc_pkg::SMOC_CMD_ONE);
	assign call_cmd = out_cmd(code, smoc_pkg::SMOC_CMD_ON);
	// Send is refused outside data mode, call while the line is occupied
	assign cmd_ack = is_cmd && !(rts_cmd && !pins.ready)
		&& !(call_cmd && pins.occupied);
	// Free while dialing or while a send is pending; never with an error
	assign dout_ack = is_dout && !hold_full_reg && !oerr_reg
		&& (dialing_reg || rts_reg);
	assign host_ack = cmd_ack || dout_ack;

	////////////////////////////////////////////////////////////////////////
	// Data set and dialer control

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rts_reg <= 1'b0;
			tr_reg <= 1'b0;
		end else begin
			if (cmd_ack && rts_cmd)
				rts_reg <= 1'b1;
			else if (out_cmd(code, smoc_pkg::SMOC_CMD_OFF))
				rts_reg <= 1'b0;
			if (in_cmd(code, smoc_pkg::SMOC_CMD_ON))
				tr_reg <= 1'b1;
			else if (in_cmd(code, smoc_pkg::SMOC_CMD_OFF))
				tr_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dialing_reg <= 1'b0;
		end else begin
			if (cmd_ack && call_cmd)
				dialing_reg <= 1'b1;
			else if (out_cmd(code, smoc_pkg::SMOC_CMD_DIAL_DONE))
				dialing_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dial_digit <= 4'h0;
			dial_digit_valid <= 1'b0;
			rearm_input <= 1'b0;
		end else begin
			dial_digit_valid <= dout_ack && dialing_reg;
			if (dout_ack && dialing_reg)
				dial_digit <= host_req.acc[8:11];
			rearm_input <= in_cmd(code, smoc_pkg::SMOC_CMD_ONE);
		end
	end

	assign rts = rts_reg;
	assign terminal_ready = tr_reg;
	assign dial_off_hook = dialing_reg;

	////////////////////////////////////////////////////////////////////////
	// Holding register and crossing to the transmit clock

	// One word in flight: the next move waits for the shifter to take it
	assign hold_moves = hold_full_reg && pins.cts && rts_reg
		&& (xfer_req_reg == ack_seen_reg);
	assign underrun = link_err_s != err_seen_reg;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hold_full_reg <= 1'b0;
			hold_reg <= smoc_pkg::SMOC_HOLD_RST;
			link_word_reg <= smoc_pkg::SMOC_HOLD_RST;
			xfer_req_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			err_seen_reg <= 1'b0;
		end else begin
			ack_seen_reg <= link_ack_s;
			err_seen_reg <= link_err_s;
			if (dout_ack && !dialing_reg) begin
				hold_full_reg <= 1'b1;
				hold_reg <= host_req.acc[8:15];
			end else if (hold_moves) begin
				hold_full_reg <= 1'b0;
				link_word_reg <= hold_reg;
				xfer_req_reg <= ~xfer_req_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Service requests

	logic ev_ready_chg;
	logic ev_free;
	logic ev_next;
	logic ev_abandon;
	logic out_ev;
	logic out_need_reg;
	logic out_allow_reg;
	logic in_need_reg;
	logic in_allow_reg;
	logic out_clr;
	logic in_clr;
	logic stat_out;
	logic stat_in;

	assign ev_ready_chg = pins.ready != pins_d_reg.ready;
	assign ev_free = hold_moves;
	assign ev_next = pins.next_digit && !pins_d_reg.next_digit;
	assign ev_abandon = pins.abandon && !pins_d_reg.abandon;
	assign out_ev = ev_ready_chg || ev_free || underrun
		|| (dialing_reg && ev_next) || ev_abandon;
	assign stat_out = is_stat && !is_in;
	assign stat_in = is_stat && is_in;
	assign out_clr = (cmd_ack && !is_in) || stat_out || dout_ack;
	assign in_clr = (is_cmd && is_in) || stat_in;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			pins_d_reg <= '0;
		else
			pins_d_reg <= pins;
	end

	// A new event in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			out_need_reg <= 1'b0;
			out_allow_reg <= 1'b0;
			out_srq <= 1'b0;
		end else begin
			// Masking keeps the pending condition for a later unmask
			if (out_ev)
				out_need_reg <= 1'b1;
			else if (out_clr
				&& !out_cmd(code, smoc_pkg::SMOC_CMD_MASK))
				out_need_reg <= 1'b0;
			if (out_cmd(code, smoc_pkg::SMOC_CMD_MASK)) begin
				out_allow_reg <= 1'b0;
				out_srq <= 1'b0;
			end else if (out_cmd(code, smoc_pkg::SMOC_CMD_UNMASK)) begin
				out_allow_reg <= 1'b1;
				out_srq <= out_need_reg || out_ev;
			end else if (out_ev && out_allow_reg) begin
				out_srq <= 1'b1;
			end else if (out_clr) begin
				out_srq <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			in_need_reg <= 1'b0;
			in_allow_reg <= 1'b0;
			in_srq <= 1'b0;
		end else begin
			if (in_data_event || in_terr_event)
				in_need_reg <= 1'b1;
			else if (in_clr
				&& !in_cmd(code, smoc_pkg::SMOC_CMD_MASK))
				in_need_reg <= 1'b0;
			if (in_cmd(code, smoc_pkg::SMOC_CMD_MASK)) begin
				in_allow_reg <= 1'b0;
				in_srq <= 1'b0;
			end else if (in_cmd(code, smoc_pkg::SMOC_CMD_UNMASK)) begin
				in_allow_reg <= 1'b1;
				in_srq <= in_need_reg || in_data_event || in_terr_event;
			end else if ((in_data_event || in_terr_event) && in_allow_reg) begin
				in_srq <= 1'b1;
			end else if (in_clr) begin
				in_srq <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timing errors and status

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			oerr_reg <= 1'b0;
			ierr_reg <= 1'b0;
			abandon_reg <= 1'b0;
		end else begin
			if (underrun)
				oerr_reg <= 1'b1;
			else if (stat_out)
				oerr_reg <= 1'b0;
			if (in_terr_event)
				ierr_reg <= 1'b1;
			else if (stat_in)
				ierr_reg <= 1'b0;
			if (ev_abandon)
				abandon_reg <= 1'b1;
			else if (stat_out)
				abandon_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			status_data <= 16'h0000;
		end else if (stat_out) begin
			status_data <= 16'h0000;
			status_data[smoc_pkg::SMOC_ST_READY] <= pins.ready;
			status_data[smoc_pkg::SMOC_ST_TERR] <= oerr_reg;
			status_data[smoc_pkg::SMOC_ST_CTS] <= pins.cts;
			status_data[smoc_pkg::SMOC_ST_NEXT] <= pins.next_digit;
			status_data[smoc_pkg::SMOC_ST_ABANDON] <= abandon_reg;
			status_data[smoc_pkg::SMOC_ST_OCCUPIED] <= pins.occupied;
		end else if (stat_in) begin
			status_data <= 16'h0000;
			status_data[smoc_pkg::SMOC_ST_TERR] <= ierr_reg;
			status_data[smoc_pkg::SMOC_ST_CARRIER] <= pins.carrier;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit clock domain

	logic lrst_meta_reg;
	logic lrst_n_reg;
	logic link_req_s;
	logic [0:7] sh_reg;
	logic [2:0] bit_reg;
	logic active_reg;
	logic word_ready;

	always_ff @(posedge tx_clk or negedge resetn) begin
		if (!resetn) begin
			lrst_meta_reg <= 1'b0;
			lrst_n_reg <= 1'b0;
		end else begin
			lrst_meta_reg <= 1'b1;
			lrst_n_reg <= lrst_meta_reg;
		end
	end

	// The word is held stable by the sender until the toggle returns
	smoc_sync #(.W(1)) u_req_sync (
		.clk(tx_clk),
		.rst_n(lrst_n_reg),
		.d(xfer_req_reg),
		.q(link_req_s)
	);

	assign word_ready = link_req_s != link_ack_tgl_reg;

	always_ff @(posedge tx_clk or negedge lrst_n_reg) begin
		if (!lrst_n_reg) begin
			sh_reg <= 8'hFF;
			bit_reg <= 3'h0;
			active_reg <= 1'b0;
			link_ack_tgl_reg <= 1'b0;
			link_err_tgl_reg <= 1'b0;
		end else if (bit_reg == smoc_pkg::SMOC_LAST_BIT || !active_reg) begin
			bit_reg <= 3'h0;
			if (word_ready) begin
				sh_reg <= link_word_reg;
				active_reg <= 1'b1;
				link_ack_tgl_reg <= ~link_ack_tgl_reg;
			end else begin
				sh_reg <= 8'hFF;
				active_reg <= 1'b0;
				if (active_reg)
					link_err_tgl_reg <= ~link_err_tgl_reg;
			end
		end else begin
			bit_reg <= bit_reg + 3'h1;
			sh_reg <= {1'b1, sh_reg[0:6]};
		end
	end

	// Last bit of the word (A15 side) goes out first
	assign txd = active_reg ? sh_reg[7] : smoc_pkg::SMOC_MARK;

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_free_move;
		hold_moves ##1 !hold_full_reg;
	endsequence

	property p_load_gate;
		@(posedge sys_clk) disable iff (!resetn)
		dout_ack |-> !hold_full_reg && (dialing_reg || rts_reg);
	endproperty
	a_load_gate: assert property (p_load_gate)
		else $error("data out taken while holding busy");

	property p_move;
		@(posedge sys_clk) disable iff (!resetn)
		hold_moves && !out_cmd(code, smoc_pkg::SMOC_CMD_MASK)
			&& out_allow_reg |-> s_free_move ##0 out_srq;
	endproperty
	a_move: assert property (p_move)
		else $error("move did not free holding and request service");

	property p_underrun;
		@(posedge sys_clk) disable iff (!resetn)
		underrun |=> oerr_reg;
	endproperty
	a_underrun: assert property (p_underrun)
		else $error("underrun did not set timing error");

	property p_idle_mark;
		@(posedge tx_clk) disable iff (!lrst_n_reg)
		!active_reg |-> txd;
	endproperty
	a_idle_mark: assert property (p_idle_mark)
		else $error("transmit line not at mark while idle");

	property p_mask;
		@(posedge sys_clk) disable iff (!resetn)
		// An unmask right behind the mask may raise the request again
		out_cmd(code, smoc_pkg::SMOC_CMD_MASK) |=> !out_srq && !out_allow_reg
			##1 (!out_srq || out_allow_reg);
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked output request still active");

	property p_unmask;
		@(posedge sys_clk) disable iff (!resetn)
		out_cmd(code, smoc_pkg::SMOC_CMD_UNMASK) && out_need_reg |=> out_srq;
	endproperty
	a_unmask: assert property (p_unmask)
		else $error("pending request not raised on unmask");

	property p_rts_refused;
		@(posedge sys_clk) disable iff (!resetn)
		rts_cmd && !pins.ready |-> !host_ack;
	endproperty
	a_rts_refused: assert property (p_rts_refused)
		else $error("send request acknowledged outside data mode");

	property p_call_refused;
		@(posedge sys_clk) disable iff (!resetn)
		call_cmd && pins.occupied && !dialing_reg |-> !host_ack
			##1 !dial_off_hook;
	endproperty
	a_call_refused: assert property (p_call_refused)
		else $error("call request taken on occupied line");

	property p_status_clear;
		@(posedge sys_clk) disable iff (!resetn)
		stat_out && !underrun && !out_ev |=> !oerr_reg && !out_srq;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status read did not clear output error");

	property p_terminal;
		@(posedge sys_clk) disable iff (!resetn)
		in_cmd(code, smoc_pkg::SMOC_CMD_OFF) |=> !terminal_ready;
	endproperty
	a_terminal: assert property (p_terminal)
		else $error("terminal ready not dropped");

endmodule

/* File: smoc_modem_model.sv */
/*
 * Data set and dialer model facing the output section.
 * Assumes the bench drives ready, carrier, occupied and abandon levels.
 */
`timescale 1ns/10ps
module smoc_modem_model #(
	parameter int CTS_DELAY = 6
) (
	// Clocks
	input wire logic sys_clk,
	output logic tx_clk,
	// Data set side
	input wire logic rts,
	input wire logic txd,
	output logic ds_cts,
	// Dialer side
	input wire logic dial_off_hook,
	input wire logic dial_digit_valid,
	output logic dial_next_digit,
	// Observation
	input wire logic [7:0] want_byte,
	output logic byte_seen
);
	logic [7:0] sh;
	logic taken;
	int dly;
	initial begin
		tx_clk = 1'b0;
		ds_cts = 1'b0;
		dial_next_digit = 1'b0;
		byte_seen = 1'b0;
		taken = 1'b0;
		sh = 8'hFF;
		dly = 0;
		#3;
		// Free running, as the data set transmitter clock never stops
		forever begin
			tx_clk = ~tx_clk;
			#16;
		end
	end
	// Clear-to-send follows request-to-send after a turnaround delay
	always @(posedge tx_clk) begin
		if (!rts) begin
			dly <= 0;
			ds_cts <= 1'b0;
		end else if (dly < CTS_DELAY) begin
			dly <= dly + 1;
		end else begin
			ds_cts <= 1'b1;
		end
	end
	// Sampled on the falling edge, away from the launch edge; first bit LSB
	always @(negedge tx_clk) begin
		sh <= {txd, sh[7:1]};
		if ({txd, sh[7:1]} == want_byte) begin
			byte_seen <= 1'b1;
		end
	end
	// One digit request after dial tone, withdrawn once the digit arrives
	always @(posedge sys_clk) begin
		taken <= dial_off_hook && (taken || dial_digit_valid);
		dial_next_digit <= dial_off_hook && !taken && !dial_digit_valid;
	end
endmodule

/* File: tb.sv */
/*
 * Self-checking bench for the modem output section and command decoder.
 * Assumes the partner model supplies tx_clk and clear-to-send.
 */
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] OA = 8'h40;
	localparam logic [7:0] IA = 8'h41;
	logic sys_clk, resetn, tx_clk, host_ack, out_srq, in_srq, rts;
	logic terminal_ready, txd, ds_ready, ds_cts, ds_carrier;
	logic dial_next_digit, dial_abandon, dial_occupied, dial_off_hook;
	logic dial_digit_valid, in_data_event, in_terr_event, rearm_input;
	logic byte_seen, ack, hit;
	logic [3:0] dial_digit;
	logic [0:15] status_data;
	smoc_pkg::smoc_req_s host_req;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	smoc_top dut (.sys_clk(sys_clk), .resetn(resetn), .tx_clk(tx_clk),
		.host_req(host_req), .host_ack(host_ack),
		.status_data(status_data), .out_srq(out_srq), .in_srq(in_srq),
		.ds_ready(ds_ready), .ds_cts(ds_cts), .ds_carrier(ds_carrier),
		.rts(rts), .terminal_ready(terminal_ready), .txd(txd),
		.dial_next_digit(dial_next_digit), .dial_abandon(dial_abandon),
		.dial_occupied(dial_occupied), .dial_off_hook(dial_off_hook),
		.dial_digit(dial_digit), .dial_digit_valid(dial_digit_valid),
		.in_data_event(in_data_event), .in_terr_event(in_terr_event),
		.rearm_input(rearm_input));
	smoc_modem_model partner (.sys_clk(sys_clk), .tx_clk(tx_clk),
		.rts(rts), .txd(txd), .ds_cts(ds_cts),
		.dial_off_hook(dial_off_hook), .dial_digit_valid(dial_digit_valid),
		.dial_next_digit(dial_next_digit), .want_byte(8'h96),
		.byte_seen(byte_seen));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Request held from one rising edge to the edge that takes it
	task automatic xfer(input smoc_pkg::smoc_op_e op, input logic [7:0] a,
		input logic [0:15] acc);
		@(posedge sys_clk);
		host_req <= '{valid: 1'b1, op: op, addr: a, acc: acc};
		@(negedge sys_clk);
		ack = host_ack;
		@(posedge sys_clk);
		host_req.valid <= 1'b0;
		#1;
	endtask
	// Upper twelve bits carry junk so a decoder leaning on them shows up
	task automatic cmd(input logic [7:0] a, input logic [3:0] c);
		xfer(smoc_pkg::SMOC_OP_CMD, a, {12'hA5C, c});
	endtask
	task automatic dout(input logic [7:0] b);
		xfer(smoc_pkg::SMOC_OP_DATA_OUT, OA, {8'h3C, b});
	endtask
	task automatic stat(input logic [7:0] a);
		xfer(smoc_pkg::SMOC_OP_STATUS_IN, a, 16'h0000);
		idle(1);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return out_srq;
			1: return dial_digit_valid;
			2: return byte_seen;
			default: return rearm_input;
		endcase
	endfunction
	task automatic wait_sig(input int s, input int n);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++) begin
			if (sig(s) === 1'b1) hit = 1'b1;
			else idle(1);
		end
	endtask
	task automatic pulse_in(input logic terr);
		@(posedge sys_clk);
		in_data_event <= !terr;
		in_terr_event <= terr;
		@(posedge sys_clk);
		in_data_event <= 1'b0;
		in_terr_event <= 1'b0;
		idle(1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("rts", rts, 0);
		chk("trdy", terminal_ready, 0);
		chk("osrq", out_srq, 0);
		chk("isrq", in_srq, 0);
		chk("txd", txd, 1);
	endtask
	task automatic t_input();
		xfer(smoc_pkg::SMOC_OP_CMD, 8'h52, 16'h0009);
		chk("foreign ack", ack, 0);
		cmd(IA, 4'h9);
		chk("ack 9", ack, 1);
		chk("trdy", terminal_ready, 1);
		cmd(IA, 4'h1);
		wait_sig(3, 4);
		chk("rearm", hit, 1);
		cmd(IA, 4'h8);
		pulse_in(1'b0);
		chk("isrq data", in_srq, 1);
		cmd(IA, 4'h4);
		chk("isrq drop", in_srq, 0);
		pulse_in(1'b0);
		chk("isrq masked", in_srq, 0);
		cmd(IA, 4'h8);
		chk("isrq unmask", in_srq, 1);
		cmd(IA, 4'h9);
		chk("isrq cmd", in_srq, 0);
		pulse_in(1'b1);
		chk("isrq terr", in_srq, 1);
		stat(IA);
		chk("isrq stat", in_srq, 0);
		cmd(IA, 4'h5);
		chk("trdy off", terminal_ready, 0);
	endtask
	task automatic t_send();
		cmd(OA, 4'h8);
		cmd(OA, 4'h1);
		chk("rts refused", ack, 0);
		chk("rts", rts, 0);
		@(posedge sys_clk);
		ds_ready <= 1'b1;
		ds_carrier <= 1'b1;
		wait_sig(0, 10);
		chk("ready srq", hit, 1);
		cmd(OA, 4'h1);
		chk("rts ack", ack, 1);
		chk("rts on", rts, 1);
		chk("osrq cmd", out_srq, 0);
		dout(8'h96);
		chk("early load", ack, 1);
		dout(8'h96);
		chk("full refused", ack, 0);
		wait_sig(0, 300);
		chk("moved srq", hit, 1);
		dout(8'h96);
		chk("refill", ack, 1);
		chk("osrq ack", out_srq, 0);
		wait_sig(0, 100);
		stat(OA);
		chk("no oerr", status_data[13], 0);
		chk("st ready", status_data[15], 1);
		chk("st cts", status_data[12], 1);
		wait_sig(0, 100);
		chk("underrun srq", hit, 1);
		dout(8'h96);
		chk("oerr refused", ack, 0);
		chk("byte out", byte_seen, 1);
		stat(OA);
		chk("oerr", status_data[13], 1);
		chk("osrq stat", out_srq, 0);
		stat(OA);
		chk("oerr clr", status_data[13], 0);
		idle(40);
		chk("mark", txd, 1);
		cmd(OA, 4'h5);
		chk("rts off", rts, 0);
	endtask
	task automatic t_dial();
		cmd(IA, 4'h9);
		@(posedge sys_clk);
		dial_occupied <= 1'b1;
		idle(4);
		cmd(OA, 4'h9);
		chk("busy ack", ack, 0);
		chk("hook busy", dial_off_hook, 0);
		@(posedge sys_clk);
		dial_occupied <= 1'b0;
		idle(4);
		cmd(OA, 4'h9);
		chk("call ack", ack, 1);
		chk("hook", dial_off_hook, 1);
		wait_sig(0, 40);
		chk("digit srq", hit, 1);
		dout(8'h7A);
		chk("digit ack", ack, 1);
		wait_sig(1, 4);
		chk("digit pulse", hit, 1);
		chk("digit", dial_digit, 4'h7);
		cmd(OA, 4'hD);
		chk("done ack", ack, 1);
		idle(4);
		chk("no cmd srq", out_srq, 0);
		@(posedge sys_clk);
		dial_abandon <= 1'b1;
		wait_sig(0, 20);
		chk("abandon srq", hit, 1);
		cmd(OA, 4'h4);
		chk("abandon masked", out_srq, 0);
		cmd(OA, 4'h8);
		chk("abandon unmask", out_srq, 1);
		stat(OA);
		chk("st abandon", status_data[9], 1);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		resetn = 1'b0;
		host_req = '0;
		{ds_ready, ds_carrier, dial_abandon, dial_occupied} = 4'h0;
		{in_data_event, in_terr_event} = 2'h0;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		idle(4);
		t_reset();
		t_input();
		t_send();
		t_dial();
		end_of_test();
	end
endmodule
